// File: verilog/sfcd_defs.vh
// Purpose: constants for the serial flash command decoder
// Assumes: opcodes are eight bits, shifted in msb first
// Notes:   class, status layout and register map live here
//
// Operation
// R1: BE is DDR dual read, 32-bit address
// R2: EB quad read cfg addr, EC 32-bit
// R3: ED DDR quad read, EE 32-bit address
// R4: 02 and 12 are page writes
// R5: 32, 38, 34 are quad page writes
// R6: 20 and 21 clear a 4 KB sector
// R7: 60 or alternate code clears whole array
// R8: D8 and DC clear one large sector
// R9: F0 is software reset
// R10: A3, 18, E5, E6 are reserved
// R11: A7 reads lock bit, A6 writes it
// R12: busy set while internal operation runs
// R13: first status read returns busy
// R14: failed program or erase sets failure flag
// R15: failure flag keeps busy at one
// R16: failure state accepts only five commands
// R17: host clears status then write-disables
// R18: clear-status clears busy and failure flags
// R19: write-disable clears the write latch
// R20: hardware or software reset restores standby
// R21: register write runs as one internal operation
// R22: other commands ignored in failure state
`ifndef SFCD_DEFS_VH
`define SFCD_DEFS_VH

// opcodes
`define SFCD_OPC_DDR_DUAL_RD_L 8'hBE
`define SFCD_OPC_QUAD_RD       8'hEB
`define SFCD_OPC_QUAD_RD_L     8'hEC
`define SFCD_OPC_DDR_QUAD_RD   8'hED
`define SFCD_OPC_DDR_QUAD_RD_L 8'hEE
`define SFCD_OPC_PAGE_WR       8'h02
`define SFCD_OPC_PAGE_WR_L     8'h12
`define SFCD_OPC_QPAGE_WR      8'h32
`define SFCD_OPC_QPAGE_WR_ALT  8'h38
`define SFCD_OPC_QPAGE_WR_L    8'h34
`define SFCD_OPC_SMALL_CLR     8'h20
`define SFCD_OPC_SMALL_CLR_L   8'h21
`define SFCD_OPC_ARRAY_CLR     8'h60
`define SFCD_OPC_ARRAY_CLR_ALT 8'hC7
`define SFCD_OPC_SECT_CLR      8'hD8
`define SFCD_OPC_SECT_CLR_L    8'hDC
`define SFCD_OPC_SOFT_RESET    8'hF0
`define SFCD_OPC_RSVD_MULTI    8'hA3
`define SFCD_OPC_RSVD_18       8'h18
`define SFCD_OPC_RSVD_E5       8'hE5
`define SFCD_OPC_RSVD_E6       8'hE6
`define SFCD_OPC_LOCK_RD       8'hA7
`define SFCD_OPC_LOCK_WR       8'hA6
`define SFCD_OPC_STATUS1_RD    8'h05
`define SFCD_OPC_STATUS2_RD    8'h07
`define SFCD_OPC_WRITE_LOCK    8'h04
`define SFCD_OPC_WRITE_EN      8'h06
`define SFCD_OPC_CLEAR_FAIL    8'h30
`define SFCD_OPC_REG_WR        8'h01

// command classes
`define SFCD_CL_OTHER   4'h0
`define SFCD_CL_READ    4'h1
`define SFCD_CL_PROG    4'h2
`define SFCD_CL_ERASE   4'h3
`define SFCD_CL_STATUS  4'h4
`define SFCD_CL_WEN     4'h5
`define SFCD_CL_WDIS    4'h6
`define SFCD_CL_CLEAR   4'h7
`define SFCD_CL_RESET   4'h8
`define SFCD_CL_LOCKRD  4'h9
`define SFCD_CL_LOCKWR  4'hA
`define SFCD_CL_REGWR   4'hB
`define SFCD_CL_RSVD    4'hC

// data lines and serial clock limits
`define SFCD_LN_1   3'h1
`define SFCD_LN_2   3'h2
`define SFCD_LN_4   3'h4
`define SFCD_MHZ_80  8'h50
`define SFCD_MHZ_104 8'h68
`define SFCD_MHZ_133 8'h85

// internal operation kinds
`define SFCD_OP_PROG   2'h0
`define SFCD_OP_ERASE  2'h1
`define SFCD_OP_REGWR  2'h2
`define SFCD_OP_LOCKWR 2'h3

// status byte bit positions
`define SFCD_ST_BUSY 0
`define SFCD_ST_WEL  1
`define SFCD_ST_EERR 5
`define SFCD_ST_PERR 6

// register map, byte addresses
`define SFCD_REG_CTRL   4'h0
`define SFCD_REG_STATUS 4'h4
`define SFCD_REG_LAST   4'h8
`define SFCD_CTRL_ADDR4 0
`define SFCD_CTRL_RST   32'h0000_0000

`endif

// File: verilog/sfcd_decoder.v
// Purpose: command decoder and status tracker of a serial flash
// Assumes: spi mode 0, opcode and status data on single lines
// Notes:   array engine outside reports done and fail per op
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`include "sfcd_defs.vh"

module sfcd_decoder (
  // clock, reset, enable
  input  wire        clock,
  input  wire        srst,
  input  wire        clk_en,
  // serial pins from the host
  input  wire        sck,
  input  wire        cs_n,
  input  wire        si,
  input  wire        hw_reset_n,
  output wire        so,
  output wire        so_oe,
  // decoded command stream
  output wire        cmd_valid,
  output wire [3:0]  cmd_class,
  output wire [7:0]  cmd_opcode,
  output wire        cmd_addr32,
  output wire [2:0]  cmd_lines,
  output wire        cmd_ddr,
  output wire [7:0]  cmd_max_mhz,
  // internal operation engine
  output wire        op_start,
  output wire [1:0]  op_kind,
  output wire        op_abort,
  input  wire        op_done,
  input  wire        op_fail,
  // register port
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output wire [31:0] reg_rdata,
  // status view
  output wire        busy_flag,
  output wire        write_latch_flag,
  output wire        fail_state
);

  // serial engine states
  localparam [2:0] ST_OPC  = 3'b001;
  localparam [2:0] ST_OUT  = 3'b010;
  localparam [2:0] ST_SKIP = 3'b100;

  // pin synchronisers, third stage only for edge detection
  reg        sck_s1_r;
  reg        sck_s2_r;
  reg        sck_s3_r;
  reg        cs_s1_r;
  reg        cs_s2_r;
  reg        cs_s3_r;
  reg        si_s1_r;
  reg        si_s2_r;
  reg        hrst_s1_r;
  reg        hrst_s2_r;

  // serial engine
  reg [2:0]  state_r;
  reg [2:0]  bitcnt_r;
  reg [6:0]  shin_r;
  reg [7:0]  shout_r;
  reg [2:0]  outcnt_r;
  reg [7:0]  outsel_r;
  reg        so_r;
  reg        pend_r;
  reg [1:0]  pend_kind_r;

  // flags and bookkeeping
  reg        run_r;
  reg [1:0]  kind_r;
  reg        wel_r;
  reg        perr_r;
  reg        eerr_r;
  reg        lock_r;
  reg [31:0] ctrl_r;
  reg [31:0] rdata_r;
  reg        cvalid_r;
  reg [16:0] cinfo_r;
  reg [7:0]  copc_r;
  reg        start_r;
  reg [1:0]  start_kind_r;
  reg        abort_r;

  wire       sck_rise = sck_s2_r & ~sck_s3_r;
  wire       sck_fall = ~sck_s2_r & sck_s3_r;
  wire       cs_rise  = cs_s2_r & ~cs_s3_r;
  wire       cs_low   = ~cs_s2_r;
  wire [7:0] opc      = {shin_r, si_s2_r};
  wire       failed   = perr_r | eerr_r;
  wire       busy     = run_r | failed; // R12 R15

  // class, long address, lines, ddr, clock limit of one opcode
  function [16:0] dec;
    input [7:0] op;
    begin
      case (op)
        `SFCD_OPC_DDR_DUAL_RD_L: // R1
          dec = {`SFCD_CL_READ, 1'b1, `SFCD_LN_2, 1'b1, `SFCD_MHZ_80};
        `SFCD_OPC_QUAD_RD: // R2
          dec = {`SFCD_CL_READ, 1'b0, `SFCD_LN_4, 1'b0, `SFCD_MHZ_104};
        `SFCD_OPC_QUAD_RD_L: // R2
          dec = {`SFCD_CL_READ, 1'b1, `SFCD_LN_4, 1'b0, `SFCD_MHZ_104};
        `SFCD_OPC_DDR_QUAD_RD: // R3
          dec = {`SFCD_CL_READ, 1'b0, `SFCD_LN_4, 1'b1, `SFCD_MHZ_80};
        `SFCD_OPC_DDR_QUAD_RD_L: // R3
          dec = {`SFCD_CL_READ, 1'b1, `SFCD_LN_4, 1'b1, `SFCD_MHZ_80};
        `SFCD_OPC_PAGE_WR: // R4
          dec = {`SFCD_CL_PROG, 1'b0, `SFCD_LN_1, 1'b0, `SFCD_MHZ_133};
        `SFCD_OPC_PAGE_WR_L: // R4
          dec = {`SFCD_CL_PROG, 1'b1, `SFCD_LN_1, 1'b0, `SFCD_MHZ_133};
        `SFCD_OPC_QPAGE_WR, `SFCD_OPC_QPAGE_WR_ALT: // R5
          dec = {`SFCD_CL_PROG, 1'b0, `SFCD_LN_4, 1'b0, `SFCD_MHZ_80};
        `SFCD_OPC_QPAGE_WR_L: // R5
          dec = {`SFCD_CL_PROG, 1'b1, `SFCD_LN_4, 1'b0, `SFCD_MHZ_80};
        `SFCD_OPC_SMALL_CLR: // R6
          dec = {`SFCD_CL_ERASE, 1'b0, `SFCD_LN_1, 1'b0, `SFCD_MHZ_133};
        `SFCD_OPC_SMALL_CLR_L: // R6
          dec = {`SFCD_CL_ERASE, 1'b1, `SFCD_LN_1, 1'b0, `SFCD_MHZ_133};
        `SFCD_OPC_ARRAY_CLR, `SFCD_OPC_ARRAY_CLR_ALT: // R7
          dec = {`SFCD_CL_ERASE, 1'b0, `SFCD_LN_1, 1'b0, `SFCD_MHZ_133};
        `SFCD_OPC_SECT_CLR: // R8
          dec = {`SFCD_CL_ERASE, 1'b0, `SFCD_LN_1, 1'b0, `SFCD_MHZ_133};
        `SFCD_OPC_SECT_CLR_L: // R8
          dec = {`SFCD_CL_ERASE, 1'b1, `SFCD_LN_1, 1'b0, `SFCD_MHZ_133};
        `SFCD_OPC_SOFT_RESET: // R9
          dec = {`SFCD_CL_RESET, 1'b0, `SFCD_LN_1, 1'b0, `SFCD_MHZ_133};
        `SFCD_OPC_RSVD_MULTI, `SFCD_OPC_RSVD_18,
        `SFCD_OPC_RSVD_E5, `SFCD_OPC_RSVD_E6: // R10
          dec = {`SFCD_CL_RSVD, 1'b0, `SFCD_LN_1, 1'b0, `SFCD_MHZ_133};
        `SFCD_OPC_LOCK_RD: // R11
          dec = {`SFCD_CL_LOCKRD, 1'b0, `SFCD_LN_1, 1'b0, `SFCD_MHZ_133};
        `SFCD_OPC_LOCK_WR: // R11
          dec = {`SFCD_CL_LOCKWR, 1'b0, `SFCD_LN_1, 1'b0, `SFCD_MHZ_133};
        `SFCD_OPC_STATUS1_RD, `SFCD_OPC_STATUS2_RD:
          dec = {`SFCD_CL_STATUS, 1'b0, `SFCD_LN_1, 1'b0, `SFCD_MHZ_133};
        `SFCD_OPC_WRITE_EN:
          dec = {`SFCD_CL_WEN, 1'b0, `SFCD_LN_1, 1'b0, `SFCD_MHZ_133};
        `SFCD_OPC_WRITE_LOCK:
          dec = {`SFCD_CL_WDIS, 1'b0, `SFCD_LN_1, 1'b0, `SFCD_MHZ_133};
        `SFCD_OPC_CLEAR_FAIL:
          dec = {`SFCD_CL_CLEAR, 1'b0, `SFCD_LN_1, 1'b0, `SFCD_MHZ_133};
        `SFCD_OPC_REG_WR:
          dec = {`SFCD_CL_REGWR, 1'b0, `SFCD_LN_1, 1'b0, `SFCD_MHZ_133};
        default:
          dec = {`SFCD_CL_OTHER, 1'b0, `SFCD_LN_1, 1'b0, `SFCD_MHZ_133};
      endcase
    end
  endfunction

  // decode of the byte completing on this sck edge
  wire [16:0] cur     = dec(opc);
  wire [3:0]  cur_cl  = cur[16:13];
  wire        byte_in = (state_r == ST_OPC) & cs_low & sck_rise &
                        (bitcnt_r == 3'h7);

  // failure state lets only five commands through
  wire fail_ok = (cur_cl == `SFCD_CL_STATUS) |
                 (cur_cl == `SFCD_CL_WDIS) |
                 (cur_cl == `SFCD_CL_CLEAR) |
                 (cur_cl == `SFCD_CL_RESET); // R16
  // while an operation runs, new writes are held off
  wire busy_ok = ~((cur_cl == `SFCD_CL_PROG) |
                   (cur_cl == `SFCD_CL_ERASE) |
                   (cur_cl == `SFCD_CL_REGWR) |
                   (cur_cl == `SFCD_CL_LOCKWR) |
                   (cur_cl == `SFCD_CL_WEN));
  wire accept  = byte_in & (failed ? fail_ok : // R22
                            (run_r ? busy_ok : 1'b1));
  wire is_op   = (cur_cl == `SFCD_CL_PROG) |
                 (cur_cl == `SFCD_CL_ERASE) |
                 (cur_cl == `SFCD_CL_REGWR) |
                 (cur_cl == `SFCD_CL_LOCKWR);
  wire soft_rst = accept & (cur_cl == `SFCD_CL_RESET); // R9
  wire hard_rst = ~hrst_s2_r;
  wire any_rst  = soft_rst | hard_rst; // R20

  // live status bytes
  wire [7:0] stat1 = ({7'h00, busy} << `SFCD_ST_BUSY) | // R13
                     ({7'h00, wel_r} << `SFCD_ST_WEL) |
                     ({7'h00, eerr_r} << `SFCD_ST_EERR) |
                     ({7'h00, perr_r} << `SFCD_ST_PERR);
  wire [7:0] out_byte = (outsel_r == `SFCD_OPC_STATUS1_RD) ? stat1 :
                        (outsel_r == `SFCD_OPC_LOCK_RD) ?
                        {7'h00, lock_r} : 8'h00;

  // synchronisers; pins come from the host's clock domain
  always @(posedge clock) begin
    if (srst) begin
      sck_s1_r  <= 1'b0;
      sck_s2_r  <= 1'b0;
      sck_s3_r  <= 1'b0;
      cs_s1_r   <= 1'b1;
      cs_s2_r   <= 1'b1;
      cs_s3_r   <= 1'b1;
      si_s1_r   <= 1'b0;
      si_s2_r   <= 1'b0;
      hrst_s1_r <= 1'b1;
      hrst_s2_r <= 1'b1;
    end else if (clk_en) begin
      sck_s1_r  <= sck;
      sck_s2_r  <= sck_s1_r;
      sck_s3_r  <= sck_s2_r;
      cs_s1_r   <= cs_n;
      cs_s2_r   <= cs_s1_r;
      cs_s3_r   <= cs_s2_r;
      si_s1_r   <= si;
      si_s2_r   <= si_s1_r;
      hrst_s1_r <= hw_reset_n;
      hrst_s2_r <= hrst_s1_r;
    end
  end

  // serial engine: opcode in, status or lock byte out
  always @(posedge clock) begin
    if (srst) begin
      state_r     <= ST_OPC;
      bitcnt_r    <= 3'h0;
      shin_r      <= 7'h00;
      shout_r     <= 8'h00;
      outcnt_r    <= 3'h0;
      outsel_r    <= 8'h00;
      so_r        <= 1'b0;
      pend_r      <= 1'b0;
      pend_kind_r <= `SFCD_OP_PROG;
    end else if (clk_en) begin
      if (~cs_low | hard_rst) begin
        // chip select high or hardware reset ends a frame, even mid byte
        state_r  <= ST_OPC;
        bitcnt_r <= 3'h0;
        outcnt_r <= 3'h0;
        so_r     <= 1'b0;
        if (cs_rise | hard_rst)
          pend_r <= 1'b0;
      end else begin
        case (state_r)
          ST_OPC: begin
            if (sck_rise) begin
              shin_r   <= opc[6:0];
              bitcnt_r <= bitcnt_r + 3'h1;
              if (bitcnt_r == 3'h7) begin
                outsel_r <= opc;
                outcnt_r <= 3'h0;
                if (accept & ((cur_cl == `SFCD_CL_STATUS) |
                              (cur_cl == `SFCD_CL_LOCKRD)))
                  state_r <= ST_OUT;
                else
                  state_r <= ST_SKIP;
                if (accept & is_op & wel_r) begin
                  pend_r <= 1'b1;
                  case (cur_cl)
                    `SFCD_CL_PROG:   pend_kind_r <= `SFCD_OP_PROG;
                    `SFCD_CL_ERASE:  pend_kind_r <= `SFCD_OP_ERASE;
                    `SFCD_CL_REGWR:  pend_kind_r <= `SFCD_OP_REGWR;
                    default:         pend_kind_r <= `SFCD_OP_LOCKWR;
                  endcase
                end
              end
            end
          end
          ST_OUT: begin
            // refresh per byte so the host sees busy change
            if (sck_fall) begin
              if (outcnt_r == 3'h0) begin
                so_r    <= out_byte[7];
                shout_r <= {out_byte[6:0], 1'b0};
              end else begin
                so_r    <= shout_r[7];
                shout_r <= {shout_r[6:0], 1'b0};
              end
              outcnt_r <= outcnt_r + 3'h1;
            end
          end
          ST_SKIP: begin
            // address and data bytes belong to other blocks
            state_r <= ST_SKIP;
          end
          default: state_r <= ST_OPC;
        endcase
      end
    end
  end

  // flags, operation tracking and command report
  always @(posedge clock) begin
    if (srst) begin
      run_r        <= 1'b0;
      kind_r       <= `SFCD_OP_PROG;
      wel_r        <= 1'b0;
      perr_r       <= 1'b0;
      eerr_r       <= 1'b0;
      lock_r       <= 1'b0;
      cvalid_r     <= 1'b0;
      cinfo_r      <= 17'h00000;
      copc_r       <= 8'h00;
      start_r      <= 1'b0;
      start_kind_r <= `SFCD_OP_PROG;
      abort_r      <= 1'b0;
    end else if (clk_en) begin
      cvalid_r <= accept;
      start_r  <= 1'b0;
      abort_r  <= any_rst & run_r;
      if (accept) begin
        cinfo_r <= cur;
        copc_r  <= opc;
      end
      // a reset clears and skips all sets; otherwise command clears come first and hardware sets below win the same cycle
      if (any_rst) begin
        run_r  <= 1'b0; // R20
        wel_r  <= 1'b0;
        perr_r <= 1'b0;
        eerr_r <= 1'b0;
      end else begin
        if (accept & (cur_cl == `SFCD_CL_CLEAR)) begin
          perr_r <= 1'b0; // R18
          eerr_r <= 1'b0; // R18
          if (failed)
            run_r <= 1'b0; // R18
        end
        if (accept & (cur_cl == `SFCD_CL_WDIS))
          wel_r <= 1'b0; // R19
        if (accept & (cur_cl == `SFCD_CL_WEN))
          wel_r <= 1'b1;
        // writes launch when chip select closes the frame
        if (cs_rise & pend_r & ~busy) begin
          run_r        <= 1'b1; // R12 R21
          kind_r       <= pend_kind_r;
          start_r      <= 1'b1;
          start_kind_r <= pend_kind_r;
        end
        if (run_r & op_done) begin
          run_r <= 1'b0; // R12
          if (op_fail) begin
            // latch stays set so the host must write-disable
            if (kind_r == `SFCD_OP_PROG)
              perr_r <= 1'b1; // R14
            if (kind_r == `SFCD_OP_ERASE)
              eerr_r <= 1'b1; // R14
          end else begin
            wel_r <= 1'b0;
            if (kind_r == `SFCD_OP_LOCKWR)
              lock_r <= 1'b1; // R11
          end
        end
      end
    end
  end

  // register port, read data one cycle after the strobe
  always @(posedge clock) begin
    if (srst) begin
      ctrl_r  <= `SFCD_CTRL_RST;
      rdata_r <= 32'h0000_0000;
    end else if (clk_en) begin
      if (reg_wr & (reg_addr == `SFCD_REG_CTRL))
        ctrl_r <= {31'h0000_0000, reg_wdata[`SFCD_CTRL_ADDR4]};
      if (reg_rd) begin
        case (reg_addr)
          `SFCD_REG_CTRL:   rdata_r <= ctrl_r;
          `SFCD_REG_STATUS: rdata_r <= {22'h000000, lock_r, failed,
                                        stat1};
          `SFCD_REG_LAST:   rdata_r <= {20'h00000, cinfo_r[16:13],
                                        copc_r};
          default:          rdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // outputs
  assign so               = so_r;
  assign so_oe            = (state_r == ST_OUT) & cs_low;
  assign cmd_valid        = cvalid_r;
  assign cmd_class        = cinfo_r[16:13];
  assign cmd_opcode       = copc_r;
  assign cmd_addr32       = cinfo_r[12] | ctrl_r[`SFCD_CTRL_ADDR4];
  assign cmd_lines        = cinfo_r[11:9];
  assign cmd_ddr          = cinfo_r[8];
  assign cmd_max_mhz      = cinfo_r[7:0];
  assign op_start         = start_r;
  assign op_kind          = start_kind_r;
  assign op_abort         = abort_r;
  assign reg_rdata        = rdata_r;
  assign busy_flag        = busy;
  assign write_latch_flag = wel_r;
  assign fail_state       = failed;

endmodule // sfcd_decoder

// File: dv/sfcd_host_model.sv
// Purpose: host controller model driving the serial pins
// Assumes: mode 0, 125 ns serial clock, clock idle low between frames
// Notes:   si keeps toggling while unused, so stale data never looks valid
module sfcd_host_model (
  // serial pins
  output logic sck,
  output logic cs_n,
  output logic si,
  input  wire  so
);
  timeunit 1ns;
  timeprecision 10ps;

  // pins idle: deselected, clock parked low
  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end

  // released data line flips so nothing reads a held bit
  always #31.25 if (cs_n) si = ~si;

  // one frame: opcode msb first, then n bytes shifted back
  task automatic frame(input logic [7:0] op, input int n,
                       output logic [7:0] rd);
    int i;
    rd   = 8'h00;
    cs_n = 1'b0;
    for (i = 0; i < 8 + 8 * n; i++) begin
      si = (i < 8) ? op[7 - i] : ~si;
      #62.5 sck = 1'b1;
      if (i >= 8) rd = {rd[6:0], so};  // sampled on rise
      #62.5 sck = 1'b0;
    end
    #62.5 cs_n = 1'b1;
    #250;  // deselect gap covers the pin synchronisers
  endtask
endmodule // sfcd_host_model

// File: dv/sfcd_decoder_properties.sv
// Purpose: port-level checks of the command decoder
// Assumes: clk_en held high, so each flag step takes one edge
// Notes:   bound to every decoder instance
`include "sfcd_defs.vh"
module sfcd_chk (
  // clock and resets
  input wire       clock,
  input wire       srst,
  input wire       hw_reset_n,
  // decoded commands and engine
  input wire       cmd_valid,
  input wire [3:0] cmd_class,
  input wire       op_start,
  input wire [1:0] op_kind,
  input wire       op_done,
  input wire       op_fail,
  // status
  input wire       busy_flag,
  input wire       write_latch_flag,
  input wire       fail_state
);
  timeunit 1ns;
  timeprecision 10ps;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  // an accepted opcode of one class
  sequence cmd_s(cl);
    cmd_valid && cmd_class == cl;
  endsequence
  // engine report while an op runs
  sequence done_s(f);
    busy_flag && !fail_state && op_done && op_fail == f;
  endsequence
  // pin held low long enough to pass the synchroniser
  sequence hw_low_s;
    !hw_reset_n [*6];
  endsequence

  fail_busy_a: assert property (fail_state |-> busy_flag)
    else $error("busy dropped while failed");
  fail_filter_a: assert property ($past(fail_state) && cmd_valid |->
    cmd_class inside {`SFCD_CL_STATUS, `SFCD_CL_WDIS, `SFCD_CL_CLEAR,
                      `SFCD_CL_RESET})
    else $error("command taken while failed");
  fail_quiet_a: assert property (fail_state |-> !op_start)
    else $error("op launched while failed");
  fail_set_a: assert property (done_s(1'b1) ##0 !op_kind[1]
    |=> fail_state)
    else $error("failed op did not latch failure");
  busy_done_a: assert property (done_s(1'b0) |=> !busy_flag)
    else $error("busy kept after good completion");
  op_busy_a: assert property (op_start |-> ##[0:1] busy_flag)
    else $error("busy not raised at launch");
  clear_status_a: assert property (cmd_s(`SFCD_CL_CLEAR)
    ##0 $past(fail_state)
    |-> ##[0:1] (!busy_flag && !fail_state))
    else $error("clear left flags set");
  write_lock_a: assert property (cmd_s(`SFCD_CL_WDIS)
    |-> ##[0:1] !write_latch_flag)
    else $error("write latch not cleared");
  soft_reset_a: assert property (cmd_s(`SFCD_CL_RESET)
    |-> ##[0:1] (!busy_flag && !write_latch_flag))
    else $error("soft reset left state");
  hard_reset_a: assert property (hw_low_s
    |-> !busy_flag && !fail_state)
    else $error("hard reset left state");
  reserved_noop_a: assert property (cmd_s(`SFCD_CL_RSVD)
    ##0 !busy_flag |=> !op_start && $stable(write_latch_flag))
    else $error("reserved code had an effect");
endmodule // sfcd_chk

bind sfcd_decoder sfcd_chk sfcd_chk_inst (
  .clock, .srst, .hw_reset_n, .cmd_valid, .cmd_class, .op_start,
  .op_kind, .op_done, .op_fail, .busy_flag, .write_latch_flag,
  .fail_state);

// File: dv/sfcd_decoder_bench.sv
// Purpose: self-checking bench of the command decoder
// Assumes: engine model finishes each op 400 cycles after launch
// Notes:   clk_en drops once, only while the serial port is idle
`include "sfcd_defs.vh"
module sfcd_decoder_bench;
  timeunit 1ns;
  timeprecision 10ps;

  logic        clock, srst, clk_en, hw_reset_n, reg_wr, reg_rd;
  logic        sck, cs_n, si, so, so_oe, cmd_valid, cmd_addr32, cmd_ddr;
  logic        op_start, op_abort, busy_flag, write_latch_flag, fail_state;
  logic [3:0]  reg_addr, cmd_class;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [7:0]  cmd_opcode, cmd_max_mhz, st;
  logic [2:0]  cmd_lines;
  logic [1:0]  op_kind;
  logic        op_done = 1'b0;
  logic        op_fail = 1'b0;
  logic        eng_fail = 1'b0;
  int          failures = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          nvalid = 0;
  int          eng_cnt = 0;
  int          nabort = 0;
  int          noe = 0;

  sfcd_decoder sfcd_decoder_inst (
    .clock, .srst, .clk_en, .sck, .cs_n, .si, .hw_reset_n, .so, .so_oe,
    .cmd_valid, .cmd_class, .cmd_opcode, .cmd_addr32, .cmd_lines,
    .cmd_ddr, .cmd_max_mhz, .op_start, .op_kind, .op_abort, .op_done,
    .op_fail, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .busy_flag, .write_latch_flag, .fail_state);
  sfcd_host_model sfcd_host_model_inst (.sck, .cs_n, .si, .so);

  // clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // engine model, plus opcode counter and watchdog
  always @(posedge clock) begin
    op_done <= op_start ? 1'b0 : (eng_cnt == 1);
    op_fail <= eng_fail;
    eng_cnt <= op_start ? 400 : (eng_cnt > 0 ? eng_cnt - 1 : 0);
    if (cmd_valid) nvalid <= nvalid + 1;
    if (op_abort) nabort <= nabort + 1;
    if (so_oe) noe <= noe + 1;
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      summarize();
    end
  end

  task automatic check(input logic [31:0] got, exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what,
               got, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // register port: one-cycle strobes, read data a cycle later
  task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a, output logic [31:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    v = reg_rdata;
  endtask

  task automatic send(input logic [7:0] op, input int n);
    sfcd_host_model_inst.frame(op, n, st);
  endtask

  // table: opcode, class, addr check, lines, ddr, speed limit
  task automatic test_decode();
    logic [31:0] t [0:22];
    logic [31:0] w;
    int n0;
    t = '{32'hBE132150, 32'hEB124068, 32'hEC134068, 32'hED124150,
          32'hEE134150, 32'h02221085, 32'h12231085, 32'h32224050,
          32'h38224050, 32'h34234050, 32'h20320000, 32'h21330000,
          32'h60300000, 32'hC7300000, 32'hD8320000, 32'hDC330000,
          32'hF0800085, 32'hA3C00000, 32'h18C00000, 32'hE5C00000,
          32'hE6C00000, 32'hA7900000, 32'hA6A00000};
    n0 = nvalid;
    foreach (t[i]) begin
      w = t[i];
      send(w[31:24], 0);
      check(cmd_opcode, w[31:24], "opcode");
      check(cmd_class, w[23:20], "class");
      if (w[17]) check(cmd_addr32, w[16], "addr32");
      if (w[15:12] != 0)
        check({cmd_lines, cmd_ddr}, {w[14:12], w[8]}, "lines");
      if (w[7:0] != 0) check(cmd_max_mhz, w[7:0], "limit");
    end
    check(nvalid - n0, 23, "pulses");
    check(busy_flag, 0, "no op without latch");
    $display("test_decode done");
  endtask

  task automatic test_busy();
    int n0;
    send(8'h06, 0);
    send(8'h02, 0);
    check({op_kind, busy_flag}, {`SFCD_OP_PROG, 1'b1}, "kind");
    n0 = noe;
    send(8'h05, 1);
    check(st[1:0], 2'h3, "status mid-op");
    check(noe > n0, 1, "so driven");
    check(so_oe, 0, "so released");
    repeat (400) @(posedge clock);
    send(8'h05, 1);
    check(st, 8'h00, "status idle");
    $display("test_busy done");
  endtask

  task automatic fail_enter(input logic [7:0] op, input int b);
    eng_fail = 1'b1;
    send(8'h06, 0);
    send(op, 0);
    repeat (420) @(posedge clock);
    eng_fail <= 1'b0;
    send(8'h05, 1);
    check(st[b], 1, "fail bit");
    check(st[0], 1, "busy held");
  endtask

  task automatic test_fail();
    int n0;
    fail_enter(8'hD8, `SFCD_ST_EERR);
    n0 = nvalid;
    send(8'h06, 0);
    send(8'h02, 0);
    send(8'hA6, 0);
    check(nvalid - n0, 0, "refused");
    send(8'h07, 0);
    check(nvalid - n0, 1, "status2 taken");
    check(fail_state, 1, "still failed");
    // host recovery: clear status, then disable writes
    send(8'h30, 0);
    check({busy_flag, fail_state}, 0, "cleared");
    check(write_latch_flag, 1, "latch kept");
    send(8'h04, 0);
    check(write_latch_flag, 0, "latch off");
    fail_enter(8'h02, `SFCD_ST_PERR);
    send(8'hF0, 0);
    check({busy_flag, fail_state}, 0, "soft reset");
    fail_enter(8'h20, `SFCD_ST_EERR);
    @(posedge clock) hw_reset_n <= 1'b0;
    repeat (8) @(posedge clock);
    hw_reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    check({busy_flag, fail_state}, 0, "hard reset");
    $display("test_fail done");
  endtask

  task automatic test_regs();
    reg_write(4'h0, 32'hFFFF_FFFF);
    reg_read(4'h0, d);
    check(d, 1, "ctrl");
    send(8'hEB, 0);
    check(cmd_addr32, 1, "cfg long addr");
    reg_write(4'h0, 32'h0);
    reg_write(4'hC, 32'hFFFF_FFFF);
    reg_read(4'hC, d);
    check(d, 0, "unmapped");
    send(8'h06, 0);
    send(8'h01, 0);
    check({op_kind, busy_flag}, {`SFCD_OP_REGWR, 1'b1}, "reg op");
    repeat (400) @(posedge clock);
    check(busy_flag, 0, "reg op done");
    send(8'h06, 0);
    send(8'hA6, 0);
    check(op_kind, `SFCD_OP_LOCKWR, "lock op");
    repeat (400) @(posedge clock);
    reg_read(4'h4, d);
    check(d[9:0], 10'h200, "status reg");
    reg_read(4'h8, d);
    check(d[11:0], 12'hAA6, "last opcode");
    // soft reset in mid-operation must kill the running op
    send(8'h06, 0);
    send(8'h02, 0);
    send(8'hF0, 0);
    check(nabort, 1, "abort pulse");
    check(busy_flag, 0, "abort idle");
    // frozen clock enable must swallow a register write
    clk_en <= 1'b0;
    reg_write(4'h0, 32'h1);
    clk_en <= 1'b1;
    reg_read(4'h0, d);
    check(d, 0, "frozen write");
    $display("test_regs done");
  endtask

  // reset, then the scenarios in turn
  initial begin
    srst       = 1'b1;
    clk_en     = 1'b1;
    hw_reset_n = 1'b1;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    reg_addr   = 4'h0;
    reg_wdata  = 32'h0;
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    repeat (6) @(posedge clock);
    test_decode();
    test_busy();
    test_fail();
    test_regs();
    summarize();
  end
endmodule // sfcd_decoder_bench
